// [hdl/bms_pkg.sv]
// Constants, mode and state types for the buck mode sequencer.
// Assumes sys_clk at 40 MHz; comparator outputs arrive asynchronously.
// Function
// [R01] Three operating states only: shutdown, standby, active, chosen by enable level.
// [R02] Enable below wake threshold keeps shutdown with bias regulator off.
// [R03] Enable between wake and run enters standby, bias on, no switching.
// [R04] Above run: active, feedback detection first, then soft start and switching.
// [R05] Leave active for standby only below run threshold minus hysteresis.
// [R06] Enable below wake threshold returns the device to shutdown.
// [R07] About one millisecond delay after run crossing before soft start.
// [R08] Soft-start ramp lasts about 2.58 milliseconds.
// [R09] About two milliseconds after soft start before power good rises.
// [R10] Forced continuous mode blocked until soft start has fully elapsed.
// [R11] Each external clock rising edge starts a high-side on-phase.
// [R12] External clock replaces internal oscillator; frequency foldback still works.
// [R13] Synchronised operation behaves as forced continuous, conducting at light load.
// [R14] Without clock pulses, static pin level picks automatic or forced continuous.
// [R15] Automatic mode allows pulse skipping and diode emulation.
// [R16] Forced continuous disables diode emulation, allows negative current, full frequency.
// [R17] Sync mode follows applied clock unless minimum on/off time prevents it.
// [R18] Minimum on/off time limits lower switching frequency automatically.
// [R19] Host applies a valid sync clock first to start pulse control.
// [R20] Steady high forced continuous, steady low automatic, toggling clock synchronised.
// [R21] Level constant beyond mode hold time selects automatic or forced continuous.
// [R22] Mode level held at least 18 us before a mode change.
// [R23] A phase counts as a pulse only if at least 100 ns long; the code counts every pin rising edge after the first three since reset.
// [R24] Pulses no further apart than sync window count as sync clock.
// [R25] Comparator and mode pin inputs are synchronised before any decision.
// [R26] Power good held low in shutdown, standby, delay and soft start.
package bms_pkg;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned LINK_PERIOD_NS = 30;
    // Times as printed
    localparam int unsigned START_DELAY_US = 1000;
    localparam int unsigned SOFT_START_NS  = 2580000;
    localparam int unsigned GOOD_DELAY_US  = 2000;
    localparam int unsigned MODE_HOLD_NS   = 18000;
    localparam int unsigned PULSE_MIN_NS   = 100;
    localparam int unsigned SYNC_MAX_NS    = 12000;
    localparam int unsigned FB_DETECT_CYC  = 64;
    // Cycle counts: least times round up, longest times round down
    localparam int unsigned START_DELAY_CYC =
        (START_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_START_CYC =
        (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GOOD_DELAY_CYC =
        (GOOD_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MODE_HOLD_CYC =
        (MODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Pulse qualifier count is in link clock cycles
    localparam int unsigned PULSE_MIN_LCYC =
        (PULSE_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int unsigned SYNC_MAX_CYC  = SYNC_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W       = 24;

    typedef enum logic [2:0] {
        BMS_SHUTDOWN = 3'h0,
        BMS_STANDBY  = 3'h1,
        BMS_FB_DET   = 3'h3,
        BMS_DELAY    = 3'h2,
        BMS_SOFT     = 3'h6,
        BMS_GOOD_DLY = 3'h7,
        BMS_RUN      = 3'h5
    } bms_state_t;

    typedef enum logic [1:0] {
        BMS_MODE_AUTO  = 2'h0,
        BMS_MODE_FCONT = 2'h1,
        BMS_MODE_SYNC  = 2'h3
    } bms_mode_t;
endpackage : bms_pkg

// [hdl/bms_sequencer.sv]
// Enable/soft-start sequencer and mode/clock pin decoder.
// Assumes wake_cmp, run_cmp and run_hyst_cmp are async comparator levels
// and mode_clk is the mode/clock pin, also clocking the pulse qualifier.
`timescale 1ns/1ps
module bms_sequencer
    import bms_pkg::*;
#(
    parameter int unsigned START_DELAY = START_DELAY_CYC,
    parameter int unsigned SOFT_START  = SOFT_START_CYC,
    parameter int unsigned GOOD_DELAY  = GOOD_DELAY_CYC,
    parameter int unsigned MODE_HOLD   = MODE_HOLD_CYC,
    parameter int unsigned SYNC_MAX    = SYNC_MAX_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        wake_cmp,
    input  wire logic        run_cmp,
    input  wire logic        run_hyst_cmp,
    input  wire logic        mode_clk,
    input  wire logic        fb_detect_done,
    input  wire logic        foldback_req,
    output logic             bias_enable,
    output logic             switch_enable,
    output logic             soft_start_run,
    output logic             power_good_flag,
    output logic             sync_on_pulse,
    output logic             use_ext_clock,
    output logic             forced_continuous_mode,
    output logic             pulse_skip_operation,
    output logic             diode_emulation,
    output logic             freq_foldback,
    output logic [2:0]       seq_state,
    output logic [1:0]       op_mode
);

    initial begin
        if (START_DELAY < 1 || SOFT_START < 1 || GOOD_DELAY < 1 ||
            MODE_HOLD < 1 || SYNC_MAX < 1 ||
            START_DELAY >= (1 << TIMER_W) || SOFT_START >= (1 << TIMER_W) ||
            GOOD_DELAY >= (1 << TIMER_W))
            $error("bms_sequencer: timing parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] wake_s;
    logic [1:0] run_s;
    logic [1:0] hyst_s;
    logic [1:0] fb_s;
    logic [1:0] pin_s;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wake_s <= 2'h0;
            run_s  <= 2'h0;
            hyst_s <= 2'h0;
            fb_s   <= 2'h0;
            pin_s  <= 2'h0;
        end else begin
            wake_s <= {wake_s[0], wake_cmp};       // R25
            run_s  <= {run_s[0], run_cmp};         // R25
            hyst_s <= {hyst_s[0], run_hyst_cmp};   // R25
            fb_s   <= {fb_s[0], fb_detect_done};
            pin_s  <= {pin_s[0], mode_clk};        // R25
        end
    end

    logic wake;
    logic run;
    logic hyst_ok;
    logic fb_done;
    logic pin_lvl;
    assign wake    = wake_s[1];
    assign run     = run_s[1];
    assign hyst_ok = hyst_s[1];
    assign fb_done = fb_s[1];
    assign pin_lvl = pin_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Link side: count rising edges on the mode/clock pin itself, cleared only by reset.
    // The pin clock stops outside clock bursts, so a stuck level is
    // detected in the system domain by the hold timer instead.

    localparam int unsigned PW = $clog2(PULSE_MIN_LCYC + 1);

    logic [PW-1:0] hi_cnt;
    logic          pulse_tgl;

    always_ff @(posedge mode_clk or negedge rstn) begin
        if (!rstn) begin
            hi_cnt <= '0;
        end else if (hi_cnt < PW'(PULSE_MIN_LCYC)) begin
            hi_cnt <= hi_cnt + PW'(1);
        end
    end

    // One toggle per rising edge from the fourth pin clock edge after reset
    always_ff @(posedge mode_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_tgl <= 1'b0;
        end else if (hi_cnt >= PW'(PULSE_MIN_LCYC - 1)) begin
            pulse_tgl <= ~pulse_tgl;                // R23
        end
    end

    logic [2:0] tgl_s;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tgl_s <= 3'h0;
        end else begin
            tgl_s <= {tgl_s[1:0], pulse_tgl};
        end
    end

    logic pin_edge;
    assign pin_edge = tgl_s[2] ^ tgl_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    localparam int unsigned HW = $clog2(MODE_HOLD + SYNC_MAX + 2);

    logic [HW-1:0] hold_cnt;
    logic          pin_last;
    logic          seen_sync;
    bms_mode_t     mode;
    logic          ss_done;

    // Counts cycles since the pin level last changed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt <= '0;
            pin_last <= 1'b0;
        end else begin
            pin_last <= pin_lvl;
            if (pin_lvl != pin_last)
                hold_cnt <= '0;
            else if (hold_cnt <= HW'(MODE_HOLD))
                hold_cnt <= hold_cnt + HW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode      <= BMS_MODE_AUTO;
            seen_sync <= 1'b0;
        end else if (pin_edge && hold_cnt < HW'(SYNC_MAX)) begin
            mode      <= BMS_MODE_SYNC;              // R20 R24
            seen_sync <= 1'b1;                       // R19
        end else if (hold_cnt > HW'(MODE_HOLD)) begin
            // Level steady past the hold time: static selection
            mode <= pin_lvl ? BMS_MODE_FCONT : BMS_MODE_AUTO; // R14 R21 R22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable sequencer

    bms_state_t         state;
    logic [TIMER_W-1:0] timer;
    logic               timer_done;
    assign timer_done = (timer == '0);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= BMS_SHUTDOWN;
            timer <= '0;
        end else if (!wake) begin
            state <= BMS_SHUTDOWN;                   // R02 R06
            timer <= '0;
        end else begin
            if (!timer_done)
                timer <= timer - TIMER_W'(1);
            case (state)
                BMS_SHUTDOWN: begin
                    state <= BMS_STANDBY;            // R03
                end
                BMS_STANDBY: begin
                    if (run) begin
                        state <= BMS_FB_DET;         // R04
                        timer <= TIMER_W'(START_DELAY - 1);
                    end
                end
                BMS_FB_DET: begin
                    if (!hyst_ok)
                        state <= BMS_STANDBY;        // R05
                    else if (fb_done)
                        state <= BMS_DELAY;          // R04
                end
                BMS_DELAY: begin
                    if (!hyst_ok) begin
                        state <= BMS_STANDBY;        // R05
                    end else if (timer_done) begin
                        state <= BMS_SOFT;           // R07
                        timer <= TIMER_W'(SOFT_START - 1);
                    end
                end
                BMS_SOFT: begin
                    if (!hyst_ok) begin
                        state <= BMS_STANDBY;        // R05
                    end else if (timer_done) begin
                        state <= BMS_GOOD_DLY;       // R08
                        timer <= TIMER_W'(GOOD_DELAY - 1);
                    end
                end
                BMS_GOOD_DLY: begin
                    if (!hyst_ok)
                        state <= BMS_STANDBY;        // R05
                    else if (timer_done)
                        state <= BMS_RUN;            // R09
                end
                BMS_RUN: begin
                    if (!hyst_ok)
                        state <= BMS_STANDBY;        // R05
                end
                default: begin
                    state <= BMS_SHUTDOWN;           // R01
                end
            endcase
        end
    end

    assign ss_done = (state == BMS_GOOD_DLY) || (state == BMS_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic switching;
    assign switching = (state == BMS_SOFT) || ss_done;

    logic next_fcont;
    logic next_sync;
    always_comb begin
        next_sync  = (mode == BMS_MODE_SYNC) && switching;
        // Forced continuous only after soft start, sync included
        next_fcont = ss_done && (mode != BMS_MODE_AUTO);  // R10 R13
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bias_enable            <= 1'b0;
            switch_enable          <= 1'b0;
            soft_start_run         <= 1'b0;
            power_good_flag        <= 1'b0;
            use_ext_clock          <= 1'b0;
            forced_continuous_mode <= 1'b0;
            pulse_skip_operation   <= 1'b0;
            diode_emulation        <= 1'b0;
            freq_foldback          <= 1'b0;
            sync_on_pulse          <= 1'b0;
            seq_state              <= 3'h0;
            op_mode                <= 2'h0;
        end else begin
            bias_enable     <= (state != BMS_SHUTDOWN);   // R02 R03
            switch_enable   <= switching;                 // R04
            soft_start_run  <= (state == BMS_SOFT);       // R08
            power_good_flag <= (state == BMS_RUN) && hyst_ok; // R26
            use_ext_clock   <= next_sync;                 // R12 R17
            forced_continuous_mode <= next_fcont;         // R16
            pulse_skip_operation   <= switching && !next_fcont; // R15
            diode_emulation        <= switching && !next_fcont; // R15
            // Foldback stays live in every mode, sync included
            freq_foldback   <= switching && foldback_req; // R12 R18
            sync_on_pulse   <= next_sync && pin_edge;     // R11
            seq_state       <= state;
            op_mode         <= mode;
        end
    end

endmodule // bms_sequencer

// [testbench/bms_checker.sv]
// Port assertions for bms_sequencer, bound into every instance.
// Assumes every check lives in the sys_clk domain.
`timescale 1ns/1ps
module bms_checker
    import bms_pkg::*;
#(
    parameter int unsigned SOFT_START = SOFT_START_CYC
) (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       wake_cmp,
    input wire logic       bias_enable,
    input wire logic       switch_enable,
    input wire logic       soft_start_run,
    input wire logic       power_good_flag,
    input wire logic       sync_on_pulse,
    input wire logic       forced_continuous_mode,
    input wire logic       pulse_skip_operation,
    input wire logic       diode_emulation,
    input wire logic       freq_foldback,
    input wire logic [2:0] seq_state,
    input wire logic [1:0] op_mode
);
    logic [23:0] soft_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Ramp length counted here, too long for a repetition
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            soft_cnt <= 24'h0;
        else
            soft_cnt <= soft_start_run ? soft_cnt + 24'h1 : 24'h0;
    end
////////////////////////////////////////////////////////////////////////////
    a_state_legal: assert property (seq_state inside {BMS_SHUTDOWN,
        BMS_STANDBY, BMS_FB_DET, BMS_DELAY, BMS_SOFT, BMS_GOOD_DLY, BMS_RUN})
        else $error("illegal state code");
    a_bias_off: assert property (
        seq_state == BMS_SHUTDOWN |-> !bias_enable)
        else $error("bias on in shutdown");
    a_wake_drop: assert property (
        !wake_cmp [*5] |=> seq_state == BMS_SHUTDOWN)
        else $error("no shutdown after wake loss");
    a_switch_order: assert property (switch_enable |->
        seq_state inside {BMS_SOFT, BMS_GOOD_DLY, BMS_RUN})
        else $error("switching before soft start");
    a_fcont_block: assert property (forced_continuous_mode |->
        seq_state inside {BMS_GOOD_DLY, BMS_RUN})
        else $error("forced mode during start-up");
    a_soft_len: assert property (
        $fell(soft_start_run) && switch_enable |-> soft_cnt == 24'(SOFT_START))
        else $error("soft start length wrong");
    a_pg_in_run: assert property (
        power_good_flag |-> seq_state == BMS_RUN)
        else $error("power good outside run");
    a_skip_diode: assert property (pulse_skip_operation |->
        diode_emulation && !forced_continuous_mode)
        else $error("skip mode without diode emulation");
    a_sync_fcont: assert property (sync_on_pulse |->
        op_mode == BMS_MODE_SYNC && !diode_emulation)
        else $error("sync pulse outside sync mode");
    a_fold_cause: assert property (
        $rose(freq_foldback) |-> switch_enable)
        else $error("foldback without switching");
    c_pg_rise: cover property ($rose(power_good_flag));
    c_sync: cover property (sync_on_pulse);
    c_fcont: cover property (forced_continuous_mode);
    c_fold: cover property ($rose(freq_foldback));
endmodule // bms_checker

bind bms_sequencer bms_checker #(.SOFT_START(SOFT_START)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .wake_cmp(wake_cmp),
    .bias_enable(bias_enable), .switch_enable(switch_enable),
    .soft_start_run(soft_start_run), .power_good_flag(power_good_flag),
    .sync_on_pulse(sync_on_pulse),
    .forced_continuous_mode(forced_continuous_mode),
    .pulse_skip_operation(pulse_skip_operation),
    .diode_emulation(diode_emulation), .freq_foldback(freq_foldback),
    .seq_state(seq_state), .op_mode(op_mode));

// [testbench/bms_host.sv]
// Host model driving the mode/clock pin.
// Assumes a 30 ns link clock shown on the pin only inside sync frames.
`timescale 1ns/1ps
module bms_host (
    input  wire logic run_sync,
    input  wire logic level,
    output logic      mode_clk
);
    logic link_clk = 1'b0;
    // Odd start offset keeps the link unrelated to sys_clk
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Pin is steady at the requested level outside frames
    assign mode_clk = run_sync ? link_clk : level;
endmodule // bms_host

// [testbench/tb_buck_mode_sequencer.sv]
// Self-checking bench for bms_sequencer with the host pin model.
// Assumes shortened delay parameters so a start-up takes a few us.
`timescale 1ns/1ps
module tb_buck_mode_sequencer
    import bms_pkg::*;
;
    localparam int unsigned SD = 20, SS = 30, GD = 20, MH = 40, SM = 30;
    logic sys_clk = 1'b0;
    logic rstn, wake_cmp, run_cmp, run_hyst_cmp, fb_detect_done;
    logic foldback_req, run_sync, level, mode_clk, fold;
    logic bias_enable, switch_enable, soft_start_run, power_good_flag;
    logic sync_on_pulse, use_ext_clock, forced_continuous_mode;
    logic pulse_skip_operation, diode_emulation, freq_foldback;
    logic [2:0] seq_state;
    logic [1:0] op_mode;
    int err_total = 0, n_compared = 0, seed = 97, n_sync = 0;
    int n_dly, n_soft, n_good, n, t_run, cyc_n = 0;

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (sync_on_pulse === 1'b1) n_sync <= n_sync + 1;
    // Start delay runs from the run crossing, detection included
    always @(posedge sys_clk) cyc_n <= cyc_n + 1;

    bms_sequencer #(.START_DELAY(SD), .SOFT_START(SS), .GOOD_DELAY(GD),
        .MODE_HOLD(MH), .SYNC_MAX(SM)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .wake_cmp(wake_cmp),
        .run_cmp(run_cmp), .run_hyst_cmp(run_hyst_cmp), .mode_clk(mode_clk),
        .fb_detect_done(fb_detect_done), .foldback_req(foldback_req),
        .bias_enable(bias_enable), .switch_enable(switch_enable),
        .soft_start_run(soft_start_run), .power_good_flag(power_good_flag),
        .sync_on_pulse(sync_on_pulse), .use_ext_clock(use_ext_clock),
        .forced_continuous_mode(forced_continuous_mode),
        .pulse_skip_operation(pulse_skip_operation),
        .diode_emulation(diode_emulation), .freq_foldback(freq_foldback),
        .seq_state(seq_state), .op_mode(op_mode));
    bms_host HOST (.run_sync(run_sync), .level(level), .mode_clk(mode_clk));
////////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_val(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t code %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic wait_st(input logic [2:0] s, output int k);
        k = 0;
        while (seq_state !== s && k < 500) begin
            @(negedge sys_clk);
            k++;
        end
        check_bit(k < 500, 1'b1);
    endtask
    task automatic bring_up();
        @(posedge sys_clk);
        wake_cmp <= 1'b1;
        run_cmp <= 1'b1;
        run_hyst_cmp <= 1'b1;
        wait_st(BMS_FB_DET, n);
        t_run = cyc_n;
        cyc(2 + ($unsigned($random(seed)) % 6));
        check_bit(switch_enable, 1'b0);
        @(posedge sys_clk);
        fb_detect_done <= 1'b1;
        wait_st(BMS_DELAY, n);
        @(posedge sys_clk);
        fb_detect_done <= 1'b0;
        wait_st(BMS_SOFT, n_dly);
        n_dly = cyc_n - t_run;
        wait_st(BMS_GOOD_DLY, n_soft);
        wait_st(BMS_RUN, n_good);
        cyc(2);
    endtask
    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total++;
        results();
    end
    initial begin
        rstn = 1'b0; wake_cmp = 1'b0; run_cmp = 1'b0; run_hyst_cmp = 1'b0;
        fb_detect_done = 1'b0; foldback_req = 1'b0; run_sync = 1'b1;
        level = 1'b1;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        run_sync <= 1'b0;
        run_cmp <= 1'b1;
        cyc(8);
        check_val(seq_state, BMS_SHUTDOWN);
        check_bit(bias_enable, 1'b0);
        @(posedge sys_clk);
        run_cmp <= 1'b0;
        wake_cmp <= 1'b1;
        wait_st(BMS_STANDBY, n);
        cyc(3);
        check_bit(bias_enable & ~switch_enable, 1'b1);
        // Pin held high through start-up asks for forced mode early
        bring_up();
        check_bit(n_dly + 1 >= SD && n_dly <= SD + 1, 1'b1);
        check_bit(n_soft + 1 >= SS && n_soft <= SS + 1, 1'b1);
        check_bit(n_good + 1 >= GD && n_good <= GD + 1, 1'b1);
        check_bit(power_good_flag, 1'b1);
        check_val({1'b0, op_mode}, {1'b0, BMS_MODE_FCONT});
        check_bit(forced_continuous_mode & ~diode_emulation, 1'b1);
        @(posedge sys_clk);
        run_cmp <= 1'b0;
        cyc(10);
        check_val(seq_state, BMS_RUN);
        @(posedge sys_clk);
        run_hyst_cmp <= 1'b0;
        wait_st(BMS_STANDBY, n);
        cyc(2);
        check_bit(power_good_flag | switch_enable, 1'b0);
        @(posedge sys_clk);
        wake_cmp <= 1'b0;
        wait_st(BMS_SHUTDOWN, n);
        cyc(2);
        check_bit(bias_enable, 1'b0);
        bring_up();
        @(posedge sys_clk);
        level <= 1'b0;
        cyc(MH + 10);
        check_val({1'b0, op_mode}, {1'b0, BMS_MODE_AUTO});
        check_bit(pulse_skip_operation & diode_emulation, 1'b1);
        @(posedge sys_clk);
        run_sync <= 1'b1;
        cyc(20);
        n_sync = 0;
        cyc(100);
        check_val({1'b0, op_mode}, {1'b0, BMS_MODE_SYNC});
        check_bit(use_ext_clock & ~diode_emulation, 1'b1);
        check_bit(n_sync >= 70 && n_sync <= 86, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            fold = 1'($random(seed));
            foldback_req <= fold;
            cyc(4);
            check_bit(freq_foldback, fold);
        end
        @(posedge sys_clk);
        run_sync <= 1'b0;
        cyc(MH + SM + 20);
        check_val({1'b0, op_mode}, {1'b0, BMS_MODE_AUTO});
        results();
    end
endmodule // tb_buck_mode_sequencer
